// >>> inc/sfcd_pkg.sv
/*
  Shared constants for the serial flash command decoder: opcodes, lane codes,
  phase clock counts and the frame phase enumeration.
  Assumes one clock domain, mclk, shared by both ends.
*/
package sfcd_pkg;

  localparam logic [7:0] OP_ERASE_4K     = 8'h20;
  localparam logic [7:0] OP_ERASE_32K    = 8'h52;
  localparam logic [7:0] OP_ERASE_64K    = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SUSPEND      = 8'h75;
  localparam logic [7:0] OP_RESUME       = 8'h7A;
  localparam logic [7:0] OP_RD_STAT1     = 8'h05;
  localparam logic [7:0] OP_RD_STAT2     = 8'h35;
  localparam logic [7:0] OP_RD_STAT3     = 8'h15;
  localparam logic [7:0] OP_WR_STAT1     = 8'h01;
  localparam logic [7:0] OP_WR_STAT2     = 8'h31;
  localparam logic [7:0] OP_WR_STAT3     = 8'h11;
  localparam logic [7:0] OP_ID_SINGLE    = 8'h90;
  localparam logic [7:0] OP_ID_DUAL      = 8'h92;
  localparam logic [7:0] OP_ID_QUAD      = 8'h94;
  localparam logic [7:0] OP_JEDEC_ID     = 8'h9F;
  localparam logic [7:0] OP_PARAM_TABLE  = 8'h5A;
  localparam logic [7:0] OP_UNIQUE_ID    = 8'h4B;

  // Lane codes of a phase: zero means the phase is absent
  localparam logic [2:0] LANE_NONE = 3'h0;
  localparam logic [2:0] LANE_ONE  = 3'h1;
  localparam logic [2:0] LANE_TWO  = 3'h2;
  localparam logic [2:0] LANE_FOUR = 3'h4;

  localparam logic [4:0] BITS_BYTE = 5'h08;
  localparam logic [4:0] BITS_ADDR = 5'h18;
  localparam logic [5:0] DUMMY_ID   = 6'h04;
  localparam logic [5:0] DUMMY_PTAB = 6'h08;
  localparam logic [5:0] DUMMY_UID  = 6'h20;
  localparam logic [1:0] NBYTES_ONE    = 2'h1;
  localparam logic [1:0] NBYTES_TWO    = 2'h2;
  localparam logic [1:0] NBYTES_THREE  = 2'h3;
  localparam logic [1:0] NBYTES_STREAM = 2'h0;

  typedef enum logic [2:0] {
    SFCD_IDLE,
    SFCD_OPCODE,
    SFCD_ADDR,
    SFCD_DUMMY,
    SFCD_DATA,
    SFCD_IGNORE,
    SFCD_DONE
  } sfcd_phase_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] addr_lanes;
    logic [5:0] dummy;
    logic [2:0] data_lanes;
    logic       dev_drives;
    logic [1:0] nbytes;
  } sfcd_frame_t;

  // Frame shape of an opcode, all zero for an unknown one
  function automatic sfcd_frame_t sfcd_lookup(input logic [7:0] op);
    sfcd_frame_t f;
    f = '0;
    unique case (op)
      OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K: begin
        f = '{1'b1, LANE_ONE, 6'h00, LANE_NONE, 1'b0, NBYTES_ONE};
      end
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_SUSPEND, OP_RESUME: begin
        f = '{1'b1, LANE_NONE, 6'h00, LANE_NONE, 1'b0, NBYTES_ONE};
      end
      OP_RD_STAT1, OP_RD_STAT2, OP_RD_STAT3: begin
        f = '{1'b1, LANE_NONE, 6'h00, LANE_ONE, 1'b1, NBYTES_ONE};
      end
      OP_WR_STAT1, OP_WR_STAT2, OP_WR_STAT3: begin
        f = '{1'b1, LANE_NONE, 6'h00, LANE_ONE, 1'b0, NBYTES_ONE};
      end
      OP_ID_SINGLE: begin
        f = '{1'b1, LANE_ONE, 6'h00, LANE_ONE, 1'b1, NBYTES_TWO};
      end
      OP_ID_DUAL: begin
        f = '{1'b1, LANE_TWO, DUMMY_ID, LANE_TWO, 1'b1, NBYTES_TWO};
      end
      OP_ID_QUAD: begin
        f = '{1'b1, LANE_FOUR, DUMMY_ID, LANE_FOUR, 1'b1, NBYTES_TWO};
      end
      OP_JEDEC_ID: begin
        f = '{1'b1, LANE_NONE, 6'h00, LANE_ONE, 1'b1, NBYTES_THREE};
      end
      OP_PARAM_TABLE: begin
        f = '{1'b1, LANE_ONE, DUMMY_PTAB, LANE_ONE, 1'b1, NBYTES_STREAM};
      end
      OP_UNIQUE_ID: begin
        f = '{1'b1, LANE_NONE, DUMMY_UID, LANE_ONE, 1'b1, NBYTES_STREAM};
      end
      default: begin
        f = '0;
      end
    endcase
    return f;
  endfunction : sfcd_lookup

  // Clocks of a phase of nbits on a given lane count (8/4/2, 24/12/6)
  function automatic logic [4:0] sfcd_clocks(input logic [4:0] nbits,
                                            input logic [2:0] lanes);
    logic [4:0] c;
    c = 5'h00;
    unique case (lanes)
      LANE_ONE:  c = nbits;
      LANE_TWO:  c = nbits >> 1;
      LANE_FOUR: c = nbits >> 2;
      default:   c = 5'h00;
    endcase
    return c;
  endfunction : sfcd_clocks

endpackage : sfcd_pkg

// >>> inc/sfcd_if.sv
/*
  Serial link between host and flash command decoder.
  Chip select, serial clock and four data lanes, each lane
  driven by one end at a time; the bench resolves the wire from the enables.
*/
`timescale 1ns/100ps
interface sfcd_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] host_io;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io;
  logic [3:0] dev_io_oe;
  logic [3:0] io_in;

  modport host (
    output cs_n,
    output sck,
    output host_io,
    output host_io_oe,
    input  io_in
  );

  modport device (
    input  cs_n,
    input  sck,
    output dev_io,
    output dev_io_oe,
    input  io_in
  );
endinterface : sfcd_if

// >>> rtl/sfcd_device.sv
/*
  Device end: decodes each opcode after chip select falls and walks the
  frame through address, dummy and data phases at the right lane width.
  Assumes the host clocks the link with sck held high for HALF mclk cycles per bit;
  pins are synchronised here. Data bytes come from / go to the user side.
*/
// Overview of operation
// - Erase 20h/52h/D8h: opcode, single-lane address only
// - C7h/60h, 75h, 7Ah: opcode-only frames
// - Status reads return one single-lane byte
// - Status writes take one single-lane byte
// - 92h dual ID with 4 dummies; 90h single
// - 94h quad ID; 9Fh returns three bytes
// - 5Ah: address, 8 dummies, streamed data
// - 4Bh: 32 dummies, streamed data, no address
// - Opcode always 8 clocks on a single lane
// - Address clocks 24/12/6 by lane count
// - Data byte clocks 8/4/2 by lanes
// - Zero-coded phases are skipped entirely
// - Unknown opcode ignored until chip select cycles
// - MSB first; frame bounded by chip select
// - Early chip select release returns to idle
`timescale 1ns/100ps
module sfcd_device
  import sfcd_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  reset_n,
  sfcd_if.device     link,
  output logic [7:0] opcode,
  output logic       cmd_start,
  output logic [23:0] addr,
  output logic       addr_valid,
  input  wire logic [7:0] tx_byte,
  output logic       tx_take,
  output logic [7:0] rx_byte,
  output logic       rx_valid,
  output logic       frame_end
);

  logic [2:0]  cs_sync;
  logic [2:0]  sck_sync;
  logic [3:0]  io_s1;
  logic [3:0]  io_s2;
  logic        cs_q;
  logic        cs_act;
  logic        tick;
  sfcd_phase_t phase;
  sfcd_frame_t frame;
  logic [5:0]  cnt;
  logic [7:0]  shreg;
  logic [23:0] ashift;
  logic [1:0]  bytes_done;
  logic [2:0]  lanes;
  logic [4:0]  byte_clks;
  logic [7:0]  op_in;
  sfcd_frame_t op_shape;

  // First stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cs_sync  <= 3'h7;
      sck_sync <= 3'h0;
      io_s1    <= 4'h0;
      io_s2    <= 4'h0;
    end else begin
      cs_sync  <= {cs_sync[1:0], link.cs_n};
      sck_sync <= {sck_sync[1:0], link.sck};
      io_s1    <= link.io_in;
      io_s2    <= io_s1;
    end
  end

  assign cs_act = !cs_sync[1];
  assign cs_q   = !cs_sync[2];
  assign tick   = sck_sync[1] & !sck_sync[2] & cs_act;
  assign lanes  = (phase == SFCD_ADDR) ? frame.addr_lanes : frame.data_lanes;
  assign byte_clks = sfcd_clocks(BITS_BYTE, frame.data_lanes);
  assign op_in     = {shreg[6:0], io_s2[0]};
  assign op_shape  = sfcd_lookup(op_in);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      phase      <= SFCD_IDLE;
      cnt        <= 6'h00;
      shreg      <= 8'h00;
      ashift     <= 24'h000000;
      frame      <= '0;
      opcode     <= 8'h00;
      bytes_done <= 2'h0;
    end else if (!cs_act) begin
      phase <= SFCD_IDLE;
    end else if (phase == SFCD_IDLE && !cs_q) begin
      phase      <= SFCD_OPCODE;
      cnt        <= 6'h00;
      bytes_done <= 2'h0;
      frame      <= '0;
    end else if (tick) begin
      unique case (phase)
        SFCD_OPCODE: begin
          shreg <= {shreg[6:0], io_s2[0]};
          cnt   <= cnt + 6'h01;
          if (cnt == 6'(BITS_BYTE - 5'h01)) begin
            opcode <= op_in;
            frame  <= op_shape;
            cnt    <= 6'h00;
            phase  <= SFCD_DONE;
          end
        end
        SFCD_ADDR: begin
          unique case (frame.addr_lanes)
            LANE_TWO:  ashift <= {ashift[21:0], io_s2[1:0]};
            LANE_FOUR: ashift <= {ashift[19:0], io_s2};
            default:   ashift <= {ashift[22:0], io_s2[0]};
          endcase
          cnt <= cnt + 6'h01;
          // No supported opcode carries mode clocks, so the address ends the phase
          if (cnt == 6'(sfcd_clocks(BITS_ADDR, frame.addr_lanes) - 5'h01)) begin
            cnt   <= 6'h00;
            phase <= SFCD_DONE;
          end
        end
        SFCD_DUMMY: begin
          cnt <= cnt + 6'h01;
          if (cnt == frame.dummy - 6'h01) begin
            cnt   <= 6'h00;
            phase <= SFCD_DATA;
          end
        end
        SFCD_DATA: begin
          unique case (frame.data_lanes)
            LANE_TWO:  shreg <= {shreg[5:0], io_s2[1:0]};
            LANE_FOUR: shreg <= {shreg[3:0], io_s2};
            default:   shreg <= {shreg[6:0], io_s2[0]};
          endcase
          cnt <= cnt + 6'h01;
          if (cnt == 6'(byte_clks - 5'h01)) begin
            cnt        <= 6'h00;
            bytes_done <= bytes_done + 2'h1;
            if (frame.nbytes != NBYTES_STREAM
                && bytes_done + 2'h1 == frame.nbytes) begin
              phase <= SFCD_IGNORE;
            end
          end
        end
        default: begin
        end
      endcase
    end else if (phase == SFCD_DONE) begin
      // Next phase chosen from the latched opcode; absent phases skipped
      if (!frame.valid) begin
        phase <= SFCD_IGNORE;
      end else if (frame.addr_lanes != LANE_NONE && !addr_valid) begin
        phase <= SFCD_ADDR;
      end else begin
        frame.addr_lanes <= LANE_NONE;
        if (frame.dummy != 6'h00) begin
          phase <= SFCD_DUMMY;
        end else if (frame.data_lanes != LANE_NONE) begin
          phase <= SFCD_DATA;
        end else begin
          phase <= SFCD_IGNORE;
        end
      end
    end
  end

  // Address reported once after its phase completes
  always_ff @(posedge mclk) begin
    if (!reset_n || !cs_act) begin
      addr_valid <= 1'b0;
      addr       <= 24'h000000;
    end else if (phase == SFCD_ADDR && tick
                 && cnt == 6'(sfcd_clocks(BITS_ADDR, frame.addr_lanes) - 5'h01)) begin
      addr_valid <= 1'b1;
      unique case (frame.addr_lanes)
        LANE_TWO:  addr <= {ashift[21:0], io_s2[1:0]};
        LANE_FOUR: addr <= {ashift[19:0], io_s2};
        default:   addr <= {ashift[22:0], io_s2[0]};
      endcase
    end
  end

  // Strobes to the user side
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cmd_start <= 1'b0;
      rx_valid  <= 1'b0;
      rx_byte   <= 8'h00;
      frame_end <= 1'b0;
    end else begin
      cmd_start <= phase == SFCD_OPCODE && tick && cnt == 6'(BITS_BYTE - 5'h01)
                   && op_shape.valid;
      frame_end <= cs_q && !cs_act;
      rx_valid  <= 1'b0;
      if (phase == SFCD_DATA && tick && !frame.dev_drives
          && cnt == 6'(byte_clks - 5'h01)) begin
        rx_valid <= 1'b1;
        unique case (frame.data_lanes)
          LANE_TWO:  rx_byte <= {shreg[5:0], io_s2[1:0]};
          LANE_FOUR: rx_byte <= {shreg[3:0], io_s2};
          default:   rx_byte <= {shreg[6:0], io_s2[0]};
        endcase
      end
    end
  end

  // Output shifter: loads a byte at each byte boundary, MSB first
  logic [7:0] tx_sh;
  // One pulse per byte at its first tick; tx_byte must stand until then
  assign tx_take = phase == SFCD_DATA && frame.dev_drives && cnt == 6'h00 && tick;
  always_ff @(posedge mclk) begin
    if (!reset_n || !cs_act) begin
      tx_sh <= 8'h00;
    end else if (phase == SFCD_DATA && frame.dev_drives && tick) begin
      unique case (frame.data_lanes)
        LANE_TWO:  tx_sh <= (cnt == 6'h00) ? {tx_byte[5:0], 2'h0} : {tx_sh[5:0], 2'h0};
        LANE_FOUR: tx_sh <= (cnt == 6'h00) ? {tx_byte[3:0], 4'h0} : {tx_sh[3:0], 4'h0};
        default:   tx_sh <= (cnt == 6'h00) ? {tx_byte[6:0], 1'b0} : {tx_sh[6:0], 1'b0};
      endcase
    end
  end

  logic [7:0] cur;
  assign cur = (cnt == 6'h00) ? tx_byte : tx_sh;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      link.dev_io    <= 4'h0;
      link.dev_io_oe <= 4'h0;
    end else if (phase == SFCD_DATA && frame.dev_drives && cs_act) begin
      unique case (lanes)
        LANE_TWO:  link.dev_io <= {2'h0, cur[7:6]};
        LANE_FOUR: link.dev_io <= cur[7:4];
        default:   link.dev_io <= {2'h0, cur[7], 1'b0};
      endcase
      unique case (lanes)
        LANE_TWO:  link.dev_io_oe <= 4'h3;
        LANE_FOUR: link.dev_io_oe <= 4'hF;
        default:   link.dev_io_oe <= 4'h2;
      endcase
    end else begin
      link.dev_io    <= 4'h0;
      link.dev_io_oe <= 4'h0;
    end
  end

endmodule : sfcd_device

// >>> rtl/sfcd_host.sv
/*
  Host end: runs one frame per request, sending opcode, address, dummy and
  data clocks shaped by the opcode, and collecting returned bytes.
  Assumes the device end samples cs_n/sck through two flip-flops.
*/
`timescale 1ns/100ps
module sfcd_host
  import sfcd_pkg::*;
#(
  parameter int HALF = 4
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  sfcd_if.host             link,
  input  wire logic        req,
  input  wire logic [7:0]  req_op,
  input  wire logic [23:0] req_addr,
  input  wire logic [7:0]  req_len,
  input  wire logic [7:0]  wr_byte,
  output logic             busy,
  output logic             wr_take,
  output logic [7:0]       rd_byte,
  output logic             rd_valid
);

  sfcd_phase_t phase;
  sfcd_frame_t frame;
  logic [7:0]  div;
  logic [5:0]  cnt;
  logic [31:0] sh;
  logic [7:0]  left;
  logic [7:0]  rsh;
  logic [2:0]  ln;
  logic        edge_now;
  logic [4:0]  nclk;

  assign busy     = phase != SFCD_IDLE;
  assign edge_now = div == 8'(HALF * 2 - 1);
  assign ln = (phase == SFCD_ADDR) ? frame.addr_lanes
            : (phase == SFCD_DATA) ? frame.data_lanes : LANE_ONE;
  assign nclk = (phase == SFCD_ADDR) ? sfcd_clocks(BITS_ADDR, ln)
              : sfcd_clocks(BITS_BYTE, ln);
  assign wr_take = phase == SFCD_DATA && !frame.dev_drives && edge_now
                   && cnt == 6'(nclk - 5'h01);

  always_ff @(posedge mclk) begin
    if (!reset_n || phase == SFCD_IDLE) begin
      div <= 8'h00;
    end else begin
      div <= edge_now ? 8'h00 : div + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      phase <= SFCD_IDLE;
      frame <= '0;
      cnt   <= 6'h00;
      sh    <= 32'h0;
      left  <= 8'h00;
    end else begin
      unique case (phase)
        SFCD_IDLE: begin
          if (req) begin
            frame <= sfcd_lookup(req_op);
            sh    <= {req_op, req_addr};
            left  <= req_len;
            cnt   <= 6'h00;
            phase <= SFCD_OPCODE;
          end
        end
        SFCD_OPCODE, SFCD_ADDR: begin
          if (edge_now) begin
            sh  <= sh << ((ln == LANE_FOUR) ? 4 : (ln == LANE_TWO) ? 2 : 1);
            cnt <= cnt + 6'h01;
            if (cnt == 6'(nclk - 5'h01)) begin
              cnt <= 6'h00;
              if (phase == SFCD_OPCODE && frame.addr_lanes != LANE_NONE) begin
                phase <= SFCD_ADDR;
              end else if (frame.dummy != 6'h00) begin
                phase <= SFCD_DUMMY;
              end else if (frame.data_lanes != LANE_NONE && left != 8'h00) begin
                phase <= SFCD_DATA;
                sh    <= {wr_byte, 24'h0};
              end else begin
                phase <= SFCD_DONE;
              end
            end
          end
        end
        SFCD_DUMMY: begin
          if (edge_now) begin
            cnt <= cnt + 6'h01;
            if (cnt == frame.dummy - 6'h01) begin
              cnt   <= 6'h00;
              phase <= (left != 8'h00) ? SFCD_DATA : SFCD_DONE;
              sh    <= {wr_byte, 24'h0};
            end
          end
        end
        SFCD_DATA: begin
          if (edge_now) begin
            sh  <= sh << ((ln == LANE_FOUR) ? 4 : (ln == LANE_TWO) ? 2 : 1);
            cnt <= cnt + 6'h01;
            if (cnt == 6'(nclk - 5'h01)) begin
              cnt  <= 6'h00;
              left <= left - 8'h01;
              sh   <= {wr_byte, 24'h0};
              if (left == 8'h01) begin
                phase <= SFCD_DONE;
              end
            end
          end
        end
        default: begin
          phase <= SFCD_IDLE;
        end
      endcase
    end
  end

  // Serial clock high in the second half of each bit period
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      link.cs_n       <= 1'b1;
      link.sck        <= 1'b0;
      link.host_io    <= 4'h0;
      link.host_io_oe <= 4'h0;
    end else begin
      link.cs_n <= phase == SFCD_IDLE || phase == SFCD_DONE;
      link.sck  <= busy && phase != SFCD_DONE && div >= 8'(HALF);
      link.host_io_oe <= 4'h0;
      link.host_io    <= 4'h0;
      if (phase == SFCD_OPCODE || phase == SFCD_ADDR
          || (phase == SFCD_DATA && !frame.dev_drives)) begin
        unique case (ln)
          LANE_TWO:  begin
            link.host_io    <= {2'h0, sh[31:30]};
            link.host_io_oe <= 4'h3;
          end
          LANE_FOUR: begin
            link.host_io    <= sh[31:28];
            link.host_io_oe <= 4'hF;
          end
          default: begin
            link.host_io    <= {3'h0, sh[31]};
            link.host_io_oe <= 4'h1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rsh      <= 8'h00;
      rd_byte  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (phase == SFCD_DATA && frame.dev_drives && edge_now) begin
        unique case (ln)
          LANE_TWO:  rsh <= {rsh[5:0], link.io_in[1:0]};
          LANE_FOUR: rsh <= {rsh[3:0], link.io_in};
          default:   rsh <= {rsh[6:0], link.io_in[1]};
        endcase
        if (cnt == 6'(nclk - 5'h01)) begin
          rd_valid <= 1'b1;
          unique case (ln)
            LANE_TWO:  rd_byte <= {rsh[5:0], link.io_in[1:0]};
            LANE_FOUR: rd_byte <= {rsh[3:0], link.io_in};
            default:   rd_byte <= {rsh[6:0], link.io_in[1]};
          endcase
        end
      end
    end
  end

endmodule : sfcd_host

// >>> bench/sfcd_props.sv
/*
  Wire checks on the host-device link: frame length per opcode, lane
  ownership per phase and an idle serial clock.
  Assumes the link signals are sampled on mclk and HALF is at least 4.
*/
`timescale 1ns/100ps
module sfcd_props (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] host_io,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io_in
);
  logic       sck_d;
  logic       cs_d;
  logic [7:0] cnt;
  logic [7:0] op;
  logic       rise;
  logic       done;
  logic       known;

  assign rise  = sck & ~sck_d;
  assign done  = cs_n & ~cs_d;
  assign known = op inside {8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h75, 8'h7A, 8'h05, 8'h35,
                            8'h15, 8'h01, 8'h31, 8'h11, 8'h90, 8'h92, 8'h94, 8'h9F, 8'h5A,
                            8'h4B};

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sck_d <= sck;
      cs_d  <= cs_n;
    end
  end

  // Held through the cs_n rise cycle so the frame length can be judged
  always_ff @(posedge mclk) begin
    if (!reset_n || cs_n) begin
      cnt <= 8'h00;
    end else if (rise) begin
      cnt <= cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      op <= 8'h00;
    end else if (!cs_n && rise && cnt < 8'h08) begin
      op <= {op[6:0], io_in[0]};
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_end(bit c);
    done && c;
  endsequence
  sequence s_bit(bit c, logic [7:0] from);
    rise && c && cnt >= from;
  endsequence

  chk_sck_idle: assert property (cs_n |-> !sck)
    else $error("sck moved outside a frame");
  chk_one_driver: assert property ((host_io_oe & dev_io_oe) == 4'h0)
    else $error("both ends drive a lane");
  chk_op_lane: assert property (rise && cnt < 8'h08 |-> host_io_oe[0] && dev_io_oe == 4'h0)
    else $error("opcode not on lane 0");
  chk_erase_len: assert property (s_end(op inside {8'h20, 8'h52, 8'hD8}) |-> cnt == 8'h20)
    else $error("erase frame length wrong");
  chk_bare_len: assert property (s_end(op inside {8'hC7, 8'h60, 8'h75, 8'h7A}) |-> cnt == 8'h08)
    else $error("opcode-only frame length wrong");
  chk_stat_len: assert property (s_end(op inside {8'h05, 8'h35, 8'h15, 8'h01, 8'h31, 8'h11})
    |-> cnt == 8'h10)
    else $error("status frame length wrong");
  chk_id_len: assert property (s_end(op inside {8'h90, 8'h92, 8'h94, 8'h9F})
    |-> cnt == (op == 8'h90 ? 8'h30 : op == 8'h94 ? 8'h16 : 8'h20))
    else $error("id frame length wrong");
  chk_dual_out: assert property (s_bit(op == 8'h92, 8'h18)
    |-> dev_io_oe == 4'h3 && host_io_oe == 4'h0)
    else $error("dual id data lanes wrong");
  chk_quad_out: assert property (s_bit(op == 8'h94, 8'h12)
    |-> dev_io_oe == 4'hF && host_io_oe == 4'h0)
    else $error("quad id data lanes wrong");
  chk_rd_lane: assert property (s_bit(op inside {8'h05, 8'h35, 8'h15, 8'h9F}, 8'h08)
    |-> dev_io_oe == 4'h2)
    else $error("read byte not on lane 1");
  chk_wr_lane: assert property (s_bit(op inside {8'h01, 8'h31, 8'h11}, 8'h08)
    |-> host_io_oe[0] && dev_io_oe == 4'h0)
    else $error("write byte not from host");
  chk_wait_len: assert property (s_bit(op inside {8'h5A, 8'h4B}, 8'h08)
    |-> dev_io_oe == (cnt >= 8'h28 ? 4'h2 : 4'h0))
    else $error("wait clocks wrong");
  chk_unknown_quiet: assert property (!cs_n && cnt >= 8'h08 && !known |-> dev_io_oe == 4'h0)
    else $error("device drove on unknown opcode");
  chk_release_idle: assert property ($rose(cs_n) |-> ##[0:4] dev_io_oe == 4'h0)
    else $error("device still drives after release");
endmodule : sfcd_props

// >>> bench/serial_flash_command_decoder_tb.sv
/*
  Bench: host and device ends joined by the link; each opcode is run as
  one frame; bytes are compared at both user sides, opcode and address at the device side.
  Assumes a pull-up on every lane of the link.
*/
`timescale 1ns/100ps
module serial_flash_command_decoder_tb;
  logic        mclk     = 1'b0;
  logic        reset_n  = 1'b0;
  logic        host_rst_n = 1'b1;
  logic        req      = 1'b0;
  logic [7:0]  req_op   = 8'h00;
  logic [23:0] req_addr = 24'h000000;
  logic [7:0]  req_len  = 8'h00;
  logic [7:0]  wr_byte  = 8'h00;
  logic [7:0]  tx_val   = 8'hC4;
  logic        busy, wr_take, rd_valid, cmd_start, addr_valid, tx_take, rx_valid, frame_end;
  logic [7:0]  rd_byte, opcode, rx_byte, got_op;
  logic [23:0] addr, got_addr;
  logic [7:0]  rd_q[$];
  logic [7:0]  rx_q[$];
  logic [7:0]  tx_q[$];
  int          bad_count, num_checks, starts, ends, wtakes;

  always #4 mclk = ~mclk;

  sfcd_if link ();
  assign link.io_in = (link.host_io_oe & link.host_io) | (~link.host_io_oe & link.dev_io_oe
                      & link.dev_io) | ~(link.host_io_oe | link.dev_io_oe);

  sfcd_host #(.HALF(4)) sfcd_host_inst (.mclk(mclk), .reset_n(reset_n & host_rst_n),
    .link(link), .req(req), .req_op(req_op), .req_addr(req_addr), .req_len(req_len),
    .wr_byte(wr_byte),
    .busy(busy), .wr_take(wr_take), .rd_byte(rd_byte), .rd_valid(rd_valid));
  sfcd_device sfcd_device_inst (.mclk(mclk), .reset_n(reset_n), .link(link),
    .opcode(opcode), .cmd_start(cmd_start), .addr(addr), .addr_valid(addr_valid),
    .tx_byte(tx_val), .tx_take(tx_take), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .frame_end(frame_end));
  sfcd_props sfcd_props_inst (.mclk(mclk), .reset_n(reset_n), .cs_n(link.cs_n),
    .sck(link.sck), .host_io(link.host_io), .host_io_oe(link.host_io_oe),
    .dev_io(link.dev_io), .dev_io_oe(link.dev_io_oe), .io_in(link.io_in));

  always @(posedge mclk) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_byte);
    if (rx_valid === 1'b1) rx_q.push_back(rx_byte);
    if (frame_end === 1'b1) ends++;
    if (wr_take === 1'b1) wtakes++;
    if (addr_valid === 1'b1) got_addr = addr;
    if (cmd_start === 1'b1) begin
      starts++;
      got_op = opcode;
    end
    if (tx_take === 1'b1) begin
      tx_q.push_back(tx_val);
      tx_val <= #1 tx_val + 8'h3B;
    end
  end

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic do_cmd(input logic [7:0] op, input logic [23:0] a, input int nrd,
                        input int nwr, input bit has_a, input bit known);
    int n;
    rd_q.delete();
    rx_q.delete();
    tx_q.delete();
    starts = 0;
    ends = 0;
    wtakes = 0;
    req_op = op;
    req_addr = a;
    req_len = 8'(nrd + nwr);
    wr_byte = op ^ 8'hA5;
    req = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    req = 1'b0;
    while (busy !== 1'b0) begin
      @(posedge mclk);
      #1;
    end
    // Device strobes trail cs_n by its synchroniser
    repeat (8) @(posedge mclk);
    #1;
    check("starts", 24'(known), 24'(starts));
    if (known) check("opcode", 24'(op), 24'(got_op));
    if (has_a) check("address", a, got_addr);
    check("frame ends", 24'h000001, 24'(ends));
    check("read count", 24'(nrd), 24'(rd_q.size()));
    check("write count", 24'(nwr), 24'(rx_q.size()));
    check("write takes", 24'(nwr), 24'(wtakes));
    check("sent count", 24'(nrd), 24'(tx_q.size()));
    for (int i = 0; i < nrd && i < rd_q.size() && i < tx_q.size(); i++) begin
      check("read byte", 24'(tx_q[i]), 24'(rd_q[i]));
    end
    if (nwr > 0 && rx_q.size() > 0) check("write byte", 24'(op ^ 8'hA5), 24'(rx_q[0]));
    $display("test %h done", op);
  endtask : do_cmd

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  initial begin
    repeat (20) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    @(posedge mclk);
    #1;
    do_cmd(8'h20, 24'h3C5A96, 0, 0, 1, 1);
    do_cmd(8'h52, 24'h81F00E, 0, 0, 1, 1);
    do_cmd(8'hD8, 24'hFFFFFF, 0, 0, 1, 1);
    do_cmd(8'hC7, 24'h000000, 0, 0, 0, 1);
    do_cmd(8'h60, 24'h000000, 0, 0, 0, 1);
    do_cmd(8'h75, 24'h000000, 0, 0, 0, 1);
    do_cmd(8'h7A, 24'h000000, 0, 0, 0, 1);
    do_cmd(8'h05, 24'h000000, 1, 0, 0, 1);
    do_cmd(8'h35, 24'h000000, 1, 0, 0, 1);
    do_cmd(8'h15, 24'h000000, 1, 0, 0, 1);
    do_cmd(8'h01, 24'h000000, 0, 1, 0, 1);
    do_cmd(8'h31, 24'h000000, 0, 1, 0, 1);
    do_cmd(8'h11, 24'h000000, 0, 1, 0, 1);
    do_cmd(8'h90, 24'h000001, 2, 0, 1, 1);
    do_cmd(8'h92, 24'hA50F3C, 2, 0, 1, 1);
    do_cmd(8'h94, 24'h5AF0C3, 2, 0, 1, 1);
    do_cmd(8'h9F, 24'h000000, 3, 0, 0, 1);
    do_cmd(8'h5A, 24'h000080, 3, 0, 1, 1);
    do_cmd(8'h4B, 24'h000000, 2, 0, 0, 1);
    do_cmd(8'hA5, 24'h000000, 0, 0, 0, 0);
    // Host reset in mid-address ends the frame early
    starts = 0;
    ends = 0;
    got_addr = 24'h000000;
    req_op = 8'h5A;
    req_addr = 24'h0F0F0F;
    req = 1'b1;
    @(posedge mclk);
    #1;
    req = 1'b0;
    repeat (120) @(posedge mclk);
    #1;
    host_rst_n = 1'b0;
    @(posedge mclk);
    #1;
    host_rst_n = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    check("cut start", 24'h000001, 24'(starts));
    check("cut address", 24'h000000, got_addr);
    check("cut ends", 24'h000001, 24'(ends));
    $display("test cut frame done");
    do_cmd(8'h20, 24'h123456, 0, 0, 1, 1);
    final_report;
  end

  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    final_report;
  end
endmodule : serial_flash_command_decoder_tb
